// ==== rtl/drc_pkg.sv ====
// Purpose: shared constants and types of the recorder control block
// Assumes: 125 MHz system clock, binary samples every 5 ms
// Notes: lengths are held in samples of the binary sample period
package drc_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int SAMPLE_MS = 5;
    localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int MAX_RECS = 100;
    localparam int LEN_MIN_MS = 100;
    localparam int LEN_MAX_MS = 1_800_000;
    localparam int LEN_DEF_MS = 1000;
    localparam int PRE_DEF_MS = 200;
    localparam int PRE_MAX_MS = 15_000;
    localparam int LEN_MIN = LEN_MIN_MS / SAMPLE_MS;
    localparam int LEN_MAX = LEN_MAX_MS / SAMPLE_MS;
    localparam int LEN_DEF = LEN_DEF_MS / SAMPLE_MS;
    localparam int PRE_DEF = PRE_DEF_MS / SAMPLE_MS;
    localparam int PRE_MAX = PRE_MAX_MS / SAMPLE_MS;
    localparam int LW = 19;
    localparam int PW = 12;
    localparam int CW = 7;
    localparam int ANA_CH_MAX = 8;
    localparam int SPC_MAX = 64;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRIG = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_CLRIDX = 8'h0c;
    localparam logic [7:0] OFS_PRE = 8'h10;
    localparam logic [7:0] OFS_LEN = 8'h14;
    localparam logic [7:0] OFS_ANA = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_COUNT = 8'h20;
    localparam logic [7:0] OFS_CAP = 8'h24;
    localparam logic [7:0] OFS_MAXLEN = 8'h28;
    localparam logic [7:0] OFS_MAXPRE = 8'h2c;
    localparam int CTRL_EN = 0;
    localparam int CTRL_RETAIN = 1;
    localparam int CMD_TRIG = 0;
    localparam int CMD_ALL = 1;
    localparam int CMD_NEW = 2;
    localparam int CMD_OLD = 3;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [5:0] ANA_RST = 6'h00;
    typedef enum logic [2:0] {
        DRC_READY, DRC_TRIGGERED, DRC_RECSTORE, DRC_STORING,
        DRC_FULL, DRC_CFGERR
    } drc_state_e;
endpackage

// ==== rtl/drc_ram.sv ====
// Purpose: pre-trigger sample ring storage
// Assumes: one write and one read port on the same clock
// Notes: read data is registered, one cycle latency
`timescale 1ns/100ps
module drc_ram #(
    parameter int W = 8,
    parameter int DEPTH = 3000,
    parameter int AW = 12
) (
    input wire logic clock_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clock_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // drc_ram

// ==== rtl/drc_top.sv ====
// Purpose: disturbance recorder control with APB settings port
// Assumes: storage memory accepts every sample and delete strobe
// Notes: binary inputs are asynchronous and synchronised here
// Notes on behaviour
// R1 - binary channels are sampled every 5 ms during capture
// R2 - capture starts on manual request or an enabled trigger source
// R3 - any binary channel may be a trigger, any combination enabled
// R4 - never more than 100 recordings stored
// R5 - recording size follows channels, sample rate and length
// R6 - disabled recorder takes no trigger and captures nothing; a capture already under way when it is disabled still runs to its end
// R7 - status is one of six recorder states
// R8 - indexed clear deletes the recording at that one-based position
// R9 - manual trigger command clears itself after use
// R10 - clear-all deletes every recording
// R11 - clear-newest deletes the latest recording only
// R12 - clear-oldest deletes the earliest remaining recording
// R13 - capacity under current settings is reported, capped at 100
// R14 - longest allowed recording under current settings is reported
// R15 - largest settable pre-trigger span is reported
// R16 - stored count updates on each capture and deletion
// R17 - constant one and zero channels exist for record and trigger
// R18 - when full, fifo mode overwrites oldest, retain mode refuses
// R19 - pre-trigger samples, default 0.2 s, lead each recording
// R20 - retain mode at capacity reports full and ignores triggers
// R21 - triggers during a capture are ignored
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module drc_top #(
    parameter int NB = 16,
    parameter int SAMPLE_CYC = drc_pkg::SAMPLE_CYC,
    parameter logic [31:0] MEM_WORDS = 32'h0100_0000
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NB-1:0] bin_i,
    output logic rec_start_o,
    output logic rec_valid_o,
    output logic [NB+1:0] rec_data_o,
    output logic rec_end_o,
    output logic del_valid_o,
    output logic [drc_pkg::CW-1:0] del_pos_o,
    output logic del_all_o
);
    localparam int NCH = NB + 2;
    localparam int DEPTH = drc_pkg::PRE_MAX;
    localparam int AW = drc_pkg::PW;
    localparam logic [31:0] CAP = 32'(drc_pkg::MAX_RECS);

    function automatic logic [31:0] div_cap(input logic [31:0] n,
        input logic [31:0] d, input logic [31:0] c);
        logic [31:0] q;
        q = (d == 32'h0) ? c : n / d;
        return (q > c) ? c : q;
    endfunction

    function automatic logic [AW-1:0] ring_add(input logic [AW:0] s);
        return (s >= (AW+1)'(DEPTH)) ? AW'(s - (AW+1)'(DEPTH)) : AW'(s);
    endfunction

    // two flops per pin before any logic looks at it
    logic [NB-1:0] bin_meta_reg, bin_sync_reg;
    logic [NCH-1:0] chan, trig_en_reg, trig_en_next;
    logic trig_lvl, trig_prev_reg, auto_trig, man_trig, any_trig;
    logic [1:0] ctrl_reg, ctrl_next;
    logic [3:0] cmd_reg, cmd_next, cmd_wr, dir_done;
    logic [31:0] idx_reg, idx_next;
    logic idx_pend_reg, idx_pend_next, idx_done;
    logic [AW-1:0] pre_reg, pre_next;
    logic [drc_pkg::LW-1:0] len_reg, len_next;
    logic [5:0] ana_reg, ana_next;
    logic [31:0] prdata_reg, prdata_next;
    logic wr_ev, hit;
    logic enable, retain, cfg_bad, full;
    logic [31:0] wps, rec_size;
    logic [drc_pkg::CW-1:0] cap_reg, cap_next, count_reg, count_next;
    logic [drc_pkg::LW-1:0] maxlen_reg, maxlen_next;
    logic [AW-1:0] maxpre_reg, maxpre_next;
    logic [19:0] div_reg, div_next;
    logic tick;
    drc_pkg::drc_state_e state_reg, state_next;
    logic [AW-1:0] wptr_reg, wptr_next, fill_reg, fill_next;
    logic [AW-1:0] npre_reg, npre_next, raddr;
    logic [drc_pkg::LW-1:0] k_reg, k_next;
    logic rd_reg, rd_next, ring_we;
    logic start_reg, start_next, valid_reg, valid_next, end_reg, end_next;
    logic [NCH-1:0] data_reg, data_next, ring_rdata;
    logic del_v_reg, del_v_next, del_all_reg, del_all_next;
    logic [drc_pkg::CW-1:0] del_pos_reg, del_pos_next;
    logic store_ev;

    always_ff @(posedge clock_i)
    begin
        bin_meta_reg <= bin_i;
        bin_sync_reg <= bin_meta_reg;
    end

    assign chan = {1'b0, 1'b1, bin_sync_reg}; // [R17]
    assign trig_lvl = |(chan & trig_en_reg); // [R3]
    assign auto_trig = trig_lvl & ~trig_prev_reg;
    assign man_trig = cmd_reg[drc_pkg::CMD_TRIG];
    assign any_trig = auto_trig | man_trig; // [R2]
    assign enable = ctrl_reg[drc_pkg::CTRL_EN];
    assign retain = ctrl_reg[drc_pkg::CTRL_RETAIN];

    // settings derived values, registered to keep dividers off paths
    always_comb
    begin
        wps = 32'h1 + 32'(ana_reg[3:0]) * (32'(drc_pkg::SPC_MAX)
            >> ana_reg[5:4]);
        rec_size = 32'(len_reg) * wps; // [R5]
        cap_next = drc_pkg::CW'(div_cap(MEM_WORDS, rec_size, CAP)); // [R13]
        maxlen_next = drc_pkg::LW'(div_cap(MEM_WORDS, wps,
            32'(drc_pkg::LEN_MAX))); // [R14]
        maxpre_next = drc_pkg::PW'(div_cap(32'(len_reg) - 32'h1, 32'h1,
            32'(drc_pkg::PRE_MAX))); // [R15]
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cap_reg <= '0;
            maxlen_reg <= '0;
            maxpre_reg <= '0;
            trig_prev_reg <= 1'b0;
        end
        else
        begin
            cap_reg <= cap_next;
            maxlen_reg <= maxlen_next;
            maxpre_reg <= maxpre_next;
            trig_prev_reg <= trig_lvl;
        end
    end

    assign cfg_bad = (len_reg < drc_pkg::LW'(drc_pkg::LEN_MIN))
        || (len_reg > drc_pkg::LW'(drc_pkg::LEN_MAX))
        || (drc_pkg::LW'(pre_reg) >= len_reg)
        || (pre_reg > AW'(DEPTH))
        || (ana_reg[3:0] > 4'(drc_pkg::ANA_CH_MAX))
        || (cap_reg == '0);
    assign full = retain && (count_reg >= cap_reg); // [R20]

    // apb slave: zero wait states, read data caught in setup phase
    assign wr_ev = psel_i & penable_i & pwrite_i;
    always_comb
    begin
        hit = 1'b1;
        case (paddr_i)
            drc_pkg::OFS_CTRL: prdata_next = {30'h0, ctrl_reg};
            drc_pkg::OFS_TRIG: prdata_next = 32'(trig_en_reg);
            drc_pkg::OFS_CMD: prdata_next = {28'h0, cmd_reg};
            drc_pkg::OFS_CLRIDX: prdata_next = idx_reg;
            drc_pkg::OFS_PRE: prdata_next = 32'(pre_reg);
            drc_pkg::OFS_LEN: prdata_next = 32'(len_reg);
            drc_pkg::OFS_ANA: prdata_next = {26'h0, ana_reg};
            drc_pkg::OFS_STAT: prdata_next = {29'h0, state_reg}; // [R7]
            drc_pkg::OFS_COUNT: prdata_next = 32'(count_reg); // [R16]
            drc_pkg::OFS_CAP: prdata_next = 32'(cap_reg);
            drc_pkg::OFS_MAXLEN: prdata_next = 32'(maxlen_reg);
            drc_pkg::OFS_MAXPRE: prdata_next = 32'(maxpre_reg);
            default:
            begin
                prdata_next = 32'h0;
                hit = 1'b0;
            end
        endcase
        if (!(psel_i && !penable_i))
        begin
            prdata_next = prdata_reg;
        end
    end
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o = prdata_reg;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        trig_en_next = trig_en_reg;
        idx_next = idx_reg;
        pre_next = pre_reg;
        len_next = len_reg;
        ana_next = ana_reg;
        cmd_wr = 4'h0;
        if (wr_ev)
        begin
            case (paddr_i)
                drc_pkg::OFS_CTRL: ctrl_next = pwdata_i[1:0];
                drc_pkg::OFS_TRIG: trig_en_next = pwdata_i[NCH-1:0];
                drc_pkg::OFS_CMD: cmd_wr = pwdata_i[3:0];
                drc_pkg::OFS_CLRIDX: idx_next = pwdata_i;
                drc_pkg::OFS_PRE: pre_next = pwdata_i[AW-1:0];
                drc_pkg::OFS_LEN: len_next = pwdata_i[drc_pkg::LW-1:0];
                drc_pkg::OFS_ANA: ana_next = pwdata_i[5:0];
                default: ;
            endcase
        end
        // a new request in the clearing cycle survives
        cmd_next = (cmd_reg & ~dir_done) | cmd_wr; // [R9]
        cmd_next[drc_pkg::CMD_TRIG] = cmd_wr[drc_pkg::CMD_TRIG]; // [R9]
        idx_pend_next = (idx_pend_reg & ~idx_done)
            | (wr_ev && paddr_i == drc_pkg::OFS_CLRIDX);
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= drc_pkg::CTRL_RST;
            trig_en_reg <= '0;
            cmd_reg <= 4'h0;
            idx_reg <= 32'h0;
            idx_pend_reg <= 1'b0;
            pre_reg <= AW'(drc_pkg::PRE_DEF); // [R19]
            len_reg <= drc_pkg::LW'(drc_pkg::LEN_DEF);
            ana_reg <= drc_pkg::ANA_RST;
            prdata_reg <= 32'h0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            trig_en_reg <= trig_en_next;
            cmd_reg <= cmd_next;
            idx_reg <= idx_next;
            idx_pend_reg <= idx_pend_next;
            pre_reg <= pre_next;
            len_reg <= len_next;
            ana_reg <= ana_next;
            prdata_reg <= prdata_next;
        end
    end

    // capture sequencer
    assign tick = (div_reg == 20'(SAMPLE_CYC - 1));
    assign ring_we = tick & enable & (state_reg != drc_pkg::DRC_TRIGGERED);
    assign raddr = ring_add((AW+1)'(wptr_reg) + (AW+1)'(DEPTH)
        - (AW+1)'(npre_reg) + (AW+1)'(k_reg));

    drc_ram #(.W(NCH), .DEPTH(DEPTH), .AW(AW)) u_ring (
        .clock_i(clock_i),
        .we_i(ring_we),
        .waddr_i(wptr_reg),
        .wdata_i(chan),
        .raddr_i(raddr),
        .rdata_o(ring_rdata)
    );

    always_comb
    begin
        div_next = tick ? 20'h0 : div_reg + 20'h1; // [R1]
        state_next = state_reg;
        wptr_next = wptr_reg;
        fill_next = fill_reg;
        npre_next = npre_reg;
        k_next = k_reg;
        rd_next = 1'b0;
        start_next = 1'b0;
        end_next = 1'b0;
        valid_next = rd_reg;
        data_next = rd_reg ? ring_rdata : data_reg;
        if (ring_we)
        begin
            wptr_next = ring_add((AW+1)'(wptr_reg) + 13'h1);
            fill_next = (fill_reg == AW'(DEPTH)) ? fill_reg
                : fill_reg + 12'h1;
        end
        case (state_reg)
            drc_pkg::DRC_READY, drc_pkg::DRC_FULL, drc_pkg::DRC_CFGERR:
            begin
                if (!enable)
                    state_next = drc_pkg::DRC_READY; // [R6]
                else if (cfg_bad)
                    state_next = drc_pkg::DRC_CFGERR;
                else if (full)
                    state_next = drc_pkg::DRC_FULL; // [R20]
                else if (state_reg != drc_pkg::DRC_READY)
                    state_next = drc_pkg::DRC_READY;
                else if (any_trig)
                begin
                    state_next = drc_pkg::DRC_TRIGGERED; // [R2]
                    start_next = 1'b1;
                    npre_next = (fill_reg < pre_reg) ? fill_reg : pre_reg;
                    k_next = '0;
                end
            end
            drc_pkg::DRC_TRIGGERED:
            begin
                // ring dump takes far fewer cycles than one sample period
                if (drc_pkg::LW'(npre_reg) != k_reg)
                begin
                    rd_next = 1'b1; // [R19]
                    k_next = k_reg + 19'h1;
                end
                else if (!rd_reg)
                begin
                    state_next = drc_pkg::DRC_RECSTORE;
                    k_next = len_reg - drc_pkg::LW'(npre_reg);
                end
            end
            drc_pkg::DRC_RECSTORE:
            begin
                if (tick)
                begin
                    valid_next = 1'b1; // [R1]
                    data_next = chan;
                    k_next = k_reg - 19'h1;
                    if (k_reg == 19'h1)
                        state_next = drc_pkg::DRC_STORING;
                end
            end
            drc_pkg::DRC_STORING:
            begin
                end_next = 1'b1;
                state_next = drc_pkg::DRC_READY;
            end
            default: state_next = drc_pkg::DRC_READY;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            div_reg <= 20'h0;
            state_reg <= drc_pkg::DRC_READY;
            wptr_reg <= '0;
            fill_reg <= '0;
            npre_reg <= '0;
            k_reg <= '0;
            rd_reg <= 1'b0;
            start_reg <= 1'b0;
            valid_reg <= 1'b0;
            end_reg <= 1'b0;
            data_reg <= '0;
        end
        else
        begin
            div_reg <= div_next;
            state_reg <= state_next;
            wptr_reg <= wptr_next;
            fill_reg <= fill_next;
            npre_reg <= npre_next;
            k_reg <= k_next;
            rd_reg <= rd_next;
            start_reg <= start_next;
            valid_reg <= valid_next;
            end_reg <= end_next;
            data_reg <= data_next;
        end
    end

    // directory of stored recordings: count and delete strobes
    assign store_ev = (state_reg == drc_pkg::DRC_STORING);
    always_comb
    begin
        count_next = count_reg;
        del_v_next = 1'b0;
        del_all_next = 1'b0;
        del_pos_next = del_pos_reg;
        dir_done = 4'h0;
        idx_done = 1'b0;
        if (store_ev)
        begin
            if (count_reg >= cap_reg && !retain)
            begin
                del_v_next = 1'b1; // [R18]
                del_pos_next = 7'h1;
            end
            else if (count_reg < cap_reg)
                count_next = count_reg + 7'h1; // [R4] [R16]
        end
        else if (cmd_reg[drc_pkg::CMD_ALL])
        begin
            del_all_next = 1'b1; // [R10]
            count_next = '0;
            dir_done[drc_pkg::CMD_ALL] = 1'b1;
        end
        else if (cmd_reg[drc_pkg::CMD_NEW])
        begin
            dir_done[drc_pkg::CMD_NEW] = 1'b1;
            if (count_reg != '0)
            begin
                del_v_next = 1'b1; // [R11]
                del_pos_next = count_reg;
                count_next = count_reg - 7'h1;
            end
        end
        else if (cmd_reg[drc_pkg::CMD_OLD])
        begin
            dir_done[drc_pkg::CMD_OLD] = 1'b1;
            if (count_reg != '0)
            begin
                del_v_next = 1'b1; // [R12]
                del_pos_next = 7'h1;
                count_next = count_reg - 7'h1;
            end
        end
        else if (idx_pend_reg)
        begin
            idx_done = 1'b1;
            if (idx_reg != 32'h0 && idx_reg <= 32'(count_reg))
            begin
                del_v_next = 1'b1; // [R8]
                del_pos_next = idx_reg[drc_pkg::CW-1:0];
                count_next = count_reg - 7'h1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            count_reg <= '0;
            del_v_reg <= 1'b0;
            del_all_reg <= 1'b0;
            del_pos_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
            del_v_reg <= del_v_next;
            del_all_reg <= del_all_next;
            del_pos_reg <= del_pos_next;
        end
    end

    assign rec_start_o = start_reg;
    assign rec_valid_o = valid_reg;
    assign rec_data_o = data_reg;
    assign rec_end_o = end_reg;
    assign del_valid_o = del_v_reg;
    assign del_pos_o = del_pos_reg;
    assign del_all_o = del_all_reg;

    AST_TICK: assert property (@(posedge clock_i) // [R1]
        disable iff (rst_i)
        tick |=> (div_reg == 20'h0 && !tick) ##1 div_reg == 20'h1)
        else $error("sample divider did not restart");
    AST_DISABLED: assert property (@(posedge clock_i) // [R6]
        disable iff (rst_i)
        (!enable && state_reg == drc_pkg::DRC_READY) |=> !rec_start_o)
        else $error("capture started while disabled");
    AST_LIMIT: assert property (@(posedge clock_i) // [R4] [R13]
        disable iff (rst_i)
        count_reg <= 7'h64 && cap_reg <= 7'h64)
        else $error("recording limit exceeded");
    AST_MANUAL: assert property (@(posedge clock_i) // [R9]
        disable iff (rst_i)
        (man_trig && !cmd_wr[0]) |=> !man_trig)
        else $error("manual trigger did not return to idle");
    AST_CLR_ALL: assert property (@(posedge clock_i) // [R10]
        disable iff (rst_i)
        (cmd_reg[1] && !store_ev) |=> (count_reg == '0 && del_all_o))
        else $error("clear all did not empty the store");
    AST_NEWEST: assert property (@(posedge clock_i) // [R11]
        disable iff (rst_i)
        (cmd_reg[2] && !cmd_reg[1] && !store_ev && count_reg != '0)
        |=> (del_valid_o && del_pos_o == $past(count_reg)
        && count_reg == $past(count_reg) - 7'h1))
        else $error("clear newest wrong position or count");
    AST_FULL: assert property (@(posedge clock_i) // [R20]
        disable iff (rst_i)
        (state_reg == drc_pkg::DRC_READY && enable && !cfg_bad && full)
        |=> state_reg == drc_pkg::DRC_FULL ##1 !rec_start_o)
        else $error("full state not reported");
    AST_NO_OVERLAP: assert property (@(posedge clock_i) // [R21]
        disable iff (rst_i)
        (state_reg != drc_pkg::DRC_READY && any_trig) |=> !rec_start_o)
        else $error("trigger accepted during capture");
    AST_START: assert property (@(posedge clock_i) // [R2]
        disable iff (rst_i)
        (state_reg == drc_pkg::DRC_READY && enable && !cfg_bad && !full
        && man_trig)
        |=> (state_reg == drc_pkg::DRC_TRIGGERED && rec_start_o))
        else $error("manual trigger did not start capture");
endmodule // drc_top

// ==== verification/drc_store_model.sv ====
// Purpose: recording storage seen from the recorder control outputs
// Assumes: accepts every sample and delete strobe at once
// Notes: keeps its own count, independent of the control registers
`timescale 1ns/100ps
module drc_store_model #(
    parameter int NB = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic rec_start_i,
    input wire logic rec_valid_i,
    input wire logic [NB+1:0] rec_data_i,
    input wire logic rec_end_i,
    input wire logic del_valid_i,
    input wire logic [6:0] del_pos_i,
    input wire logic del_all_i,
    output logic [7:0] n_stored_o,
    output logic [19:0] last_len_o,
    output logic [6:0] last_pos_o,
    output logic const_bad_o
);
    logic [19:0] len_reg;
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            n_stored_o <= 8'h00;
            len_reg <= 20'h00000;
            last_len_o <= 20'h00000;
            last_pos_o <= 7'h00;
            const_bad_o <= 1'b0;
        end
        else
        begin
            if (rec_start_i)
                len_reg <= 20'h00000;
            else if (rec_valid_i)
                len_reg <= len_reg + 20'h00001;
            // constant channels ride in the top two bits
            if (rec_valid_i && rec_data_i[NB+1:NB] !== 2'b01)
                const_bad_o <= 1'b1;
            // overwrite at capacity is a delete plus a store, net zero
            if (del_all_i)
                n_stored_o <= 8'h00;
            else
                n_stored_o <= n_stored_o + {7'h00, rec_end_i}
                    - {7'h00, del_valid_i};
            if (rec_end_i)
                last_len_o <= len_reg;
            if (del_valid_i)
                last_pos_o <= del_pos_i;
        end
    end
endmodule // drc_store_model

// ==== verification/testbench.sv ====
// Purpose: self-checking bench of the recorder control block
// Assumes: zero-wait APB slave, short sample period for simulation
// Notes: reads queue their expected word, a monitor compares them
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam int NB = 16;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ev;
    logic pready, pslverr, rs, rv, re, dv, da, cbad;
    logic [NB-1:0] bin_i = '0;
    logic [NB+1:0] rd_d;
    logic [6:0] dp, lpos;
    logic [7:0] nst;
    logic [19:0] llen;
    logic [31:0] exp_q[$];
    string nm_q[$], cur_nm;
    int errors = 0, n_compared = 0, k;
    drc_top #(.NB(NB), .SAMPLE_CYC(50), .MEM_WORDS(32'h0000_003c)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .bin_i(bin_i), .rec_start_o(rs),
        .rec_valid_o(rv), .rec_data_o(rd_d), .rec_end_o(re),
        .del_valid_o(dv), .del_pos_o(dp), .del_all_o(da));
    drc_store_model #(.NB(NB)) store (
        .clock_i(clock_i), .rst_i(rst_i), .rec_start_i(rs),
        .rec_valid_i(rv), .rec_data_i(rd_d), .rec_end_i(re),
        .del_valid_i(dv), .del_pos_i(dp), .del_all_i(da),
        .n_stored_o(nst), .last_len_o(llen), .last_pos_o(lpos),
        .const_bad_o(cbad));
    initial
    begin
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        if (psel && penable && !pwrite && pready === 1'b1
            && exp_q.size() > 0)
        begin
            ev = exp_q.pop_front();
            cur_nm = nm_q.pop_front();
            `CHK(cur_nm, ev, prdata)
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_end();
        int i;
        for (i = 0; i < 3000 && re !== 1'b1; i++)
            @(negedge clock_i);
        if (re !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED rec_end exp 1 got %b", re);
        end
        repeat (4) @(posedge clock_i);
    endtask
    task automatic capture();
        apb(1'b1, drc_pkg::OFS_CMD, 32'h1);
        wait_end();
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clock_i);
        errors++;
        end_of_test();
    end
    initial
    begin
        k = $urandom(60109);
        k = $urandom % NB;
        bin_i <= NB'($urandom) & ~(NB'(1) << k);
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        rd("stat", drc_pkg::OFS_STAT, 32'h0);
        rd("count", drc_pkg::OFS_COUNT, 32'h0);
        rd("pre", drc_pkg::OFS_PRE, 32'd40);
        rd("len", drc_pkg::OFS_LEN, 32'd200);
        rd("ctrl", drc_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, drc_pkg::OFS_LEN, 32'd20);
        apb(1'b1, drc_pkg::OFS_PRE, 32'd5);
        apb(1'b1, drc_pkg::OFS_CMD, 32'h1);
        rd("cmd", drc_pkg::OFS_CMD, 32'h0);
        repeat (100) @(posedge clock_i);
        `CHK("stored", 8'd0, nst)
        apb(1'b1, drc_pkg::OFS_CTRL, 32'h1);
        rd("maxpre", drc_pkg::OFS_MAXPRE, 32'd19);
        rd("cap", drc_pkg::OFS_CAP, 32'd3);
        apb(1'b1, drc_pkg::OFS_CMD, 32'h1);
        apb(1'b1, drc_pkg::OFS_CMD, 32'h1);
        wait_end();
        rd("count", drc_pkg::OFS_COUNT, 32'd1);
        `CHK("len", 20'd20, llen)
        apb(1'b1, drc_pkg::OFS_TRIG, 32'h1 << k);
        bin_i[k] <= 1'b1;
        wait_end();
        rd("count", drc_pkg::OFS_COUNT, 32'd2);
        apb(1'b1, drc_pkg::OFS_TRIG, 32'h0);
        apb(1'b1, drc_pkg::OFS_CTRL, 32'h3);
        capture();
        rd("stat", drc_pkg::OFS_STAT, 32'd4);
        apb(1'b1, drc_pkg::OFS_CMD, 32'h1);
        repeat (900) @(posedge clock_i);
        rd("count", drc_pkg::OFS_COUNT, 32'd3);
        apb(1'b1, drc_pkg::OFS_CTRL, 32'h1);
        capture();
        rd("count", drc_pkg::OFS_COUNT, 32'd3);
        `CHK("stored", 8'd3, nst)
        apb(1'b1, drc_pkg::OFS_CMD, 32'h4);
        rd("count", drc_pkg::OFS_COUNT, 32'd2);
        `CHK("pos", 7'd3, lpos)
        apb(1'b1, drc_pkg::OFS_CMD, 32'h8);
        rd("count", drc_pkg::OFS_COUNT, 32'd1);
        `CHK("pos", 7'd1, lpos)
        apb(1'b1, drc_pkg::OFS_CLRIDX, 32'h0);
        rd("count", drc_pkg::OFS_COUNT, 32'd1);
        apb(1'b1, drc_pkg::OFS_CLRIDX, 32'h1);
        rd("count", drc_pkg::OFS_COUNT, 32'd0);
        capture();
        capture();
        apb(1'b1, drc_pkg::OFS_CMD, 32'h2);
        rd("count", drc_pkg::OFS_COUNT, 32'd0);
        `CHK("stored", 8'd0, nst)
        `CHK("const", 1'b0, cbad)
        apb(1'b1, drc_pkg::OFS_ANA, 32'h31);
        rd("cap", drc_pkg::OFS_CAP, 32'h0);
        rd("maxlen", drc_pkg::OFS_MAXLEN, 32'h6);
        rd("stat", drc_pkg::OFS_STAT, 32'h5);
        rd("unmapped", 8'h40, 32'h0);
        `CHK("slverr", 1'b1, last_err)
        repeat (4) @(posedge clock_i);
        end_of_test();
    end
endmodule // testbench
